//--- logic/dot_matrix_lcd_controller.sv
`timescale 1ns/1ps
`default_nettype none
`include "lcd_ctl_defs.svh"

module dot_matrix_lcd_controller
  import lcd_ctl_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Host bus
  input  wire logic        chip_sel_n,
  input  wire logic        enable,
  input  wire logic        read_not_write,
  input  wire logic        register_select,
  input  wire logic [7:0]  host_data_bus_in,
  output logic      [7:0]  host_data_bus_out,
  output logic             host_data_bus_oe,
  // External memory
  output logic      [15:0] ext_mem_addr,
  input  wire logic [7:0]  ext_mem_data_in,
  output logic      [7:0]  ext_mem_data_out,
  output logic             ext_mem_data_oe,
  output logic             ext_mem_write_n,
  input  wire logic [7:0]  ext_font_data,
  // LCD drivers
  output logic             row_latch_pulse,
  output logic             dot_shift_clock,
  output logic             frame_start,
  output logic             ac_phase_type_a,
  output logic             ac_phase_type_b,
  output logic             upper_serial_out,
  output logic             lower_serial_out,
  // Parallel operation
  input  wire logic        lockstep_in,
  output logic             lockstep_out,
  output logic             lockstep_oe,
  output logic             slave_clock_out
);

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic [4:0] sync1_reg, sync2_reg;
  logic       e_d_reg;
  always_ff @(posedge ref_clk) begin
    sync1_reg <= {chip_sel_n, enable, read_not_write, register_select, lockstep_in};
    sync2_reg <= sync1_reg;
    e_d_reg   <= sync2_reg[3];
  end
  logic [7:0] db1_reg, db2_reg, md1_reg, md2_reg, rd1_reg, rd2_reg;
  always_ff @(posedge ref_clk) begin
    db1_reg <= host_data_bus_in;
    db2_reg <= db1_reg;
    md1_reg <= ext_mem_data_in;
    md2_reg <= md1_reg;
    rd1_reg <= ext_font_data;
    rd2_reg <= rd1_reg;
  end

  wire cs_s    = ~sync2_reg[4];
  wire e_s     = sync2_reg[3];
  wire rw_s    = sync2_reg[2];
  wire rs_s    = sync2_reg[1];
  wire sync_s  = sync2_reg[0];
  // Bus data held since before the fall, so the synced copy is stable
  wire e_fall  = e_d_reg & ~e_s;
  wire wr_ev   = e_fall & cs_s & ~rw_s;
  wire busy;
  wire ir_wr   = wr_ev & rs_s & ~busy;
  wire dat_wr  = wr_ev & ~rs_s & ~busy;
  wire rd_dat_end = e_fall & cs_s & rw_s & ~rs_s;

  // ==========================================================
  // Host registers
  // ==========================================================
  logic [3:0]  instruction_reg;
  logic [7:0]  data_input_latch;
  logic [7:0]  data_out_latch;
  logic [5:0]  mode_ctl_reg;
  logic [3:0]  horizontal_pitch;
  logic [3:0]  vertical_dots;
  logic [7:0]  hchars_reg;
  logic [7:0]  duty_reg;
  logic [3:0]  curpos_reg;
  logic [15:0] start_addr_reg;
  logic [15:0] cursor_addr_ctr;
  logic        dat_pend_reg;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      instruction_reg  <= 4'h0;
      data_input_latch <= 8'h00;
      dat_pend_reg     <= 1'b0;
    end else begin
      if (ir_wr)
        instruction_reg <= db2_reg[3:0];
      if (dat_wr)
        data_input_latch <= db2_reg;
      dat_pend_reg <= dat_wr;
    end
  end

  // Internal operation engine
  op_state_type state_reg, state_next;
  logic [2:0]   op_cnt_reg;
  wire mem_ic  = (instruction_reg == `IC_WRITE_MEM) || (instruction_reg == `IC_CLEAR_BIT) ||
                 (instruction_reg == `IC_SET_BIT);
  wire start_rd = (ir_wr & (db2_reg[3:0] == `IC_READ_MEM)) | rd_dat_end;
  wire start_wr = dat_pend_reg & mem_ic;
  wire op_done  = (state_reg == ST_DONE);
  assign busy   = (state_reg != ST_IDLE);

  always_comb begin
    case (state_reg)
      ST_IDLE:  state_next = start_rd ? ST_WAIT : (start_wr ? ST_ADDR : ST_IDLE);
      ST_ADDR:  state_next = (op_cnt_reg == 3'd0) ? ST_WRITE : ST_ADDR;
      ST_WAIT:  state_next = (op_cnt_reg == 3'd0) ? ST_DONE : ST_WAIT;
      ST_WRITE: state_next = (op_cnt_reg == 3'd0) ? ST_DONE : ST_WRITE;
      ST_DONE:  state_next = ST_IDLE;
      default:  state_next = ST_IDLE;
    endcase
  end

  logic [7:0]  wr_data_reg;
  wire  [2:0]  bit_sel = data_input_latch[2:0];
  wire  [7:0]  bit_mask = 8'h01 << bit_sel;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg   <= ST_IDLE;
      op_cnt_reg  <= 3'd0;
      wr_data_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg)
        op_cnt_reg <= 3'(`OP_CYCLES - 1);
      else if (op_cnt_reg != 3'd0)
        op_cnt_reg <= op_cnt_reg - 3'd1;
      if (state_reg == ST_IDLE) begin
        wr_data_reg <= data_input_latch;
      end
      // Bit ops read-modify the byte sampled during the address phase
      if (state_reg == ST_ADDR && op_cnt_reg == 3'd0)
        wr_data_reg <= (instruction_reg == `IC_SET_BIT)   ? (md2_reg | bit_mask) :
                       (instruction_reg == `IC_CLEAR_BIT) ? (md2_reg & ~bit_mask) : wr_data_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      data_out_latch   <= 8'h00;
      mode_ctl_reg     <= `MODE_RESET;
      horizontal_pitch <= `PITCH_H_RESET;
      vertical_dots    <= `PITCH_V_RESET;
      hchars_reg       <= `HCHARS_RESET;
      duty_reg         <= `DUTY_RESET;
      curpos_reg       <= 4'h0;
      start_addr_reg   <= 16'h0000;
      cursor_addr_ctr  <= 16'h0000;
    end else begin
      if (state_reg == ST_WAIT && op_cnt_reg == 3'd0)
        data_out_latch <= md2_reg;
      if (dat_pend_reg) begin
        case (instruction_reg)
          `IC_MODE:     mode_ctl_reg <= data_input_latch[5:0];
          `IC_PITCH: begin
            horizontal_pitch <= data_input_latch[3:0];
            vertical_dots    <= data_input_latch[7:4];
          end
          `IC_HCHARS:   hchars_reg <= data_input_latch;
          `IC_DUTY:     duty_reg <= data_input_latch;
          `IC_CURPOS:   curpos_reg <= data_input_latch[3:0];
          `IC_START_LO: start_addr_reg[7:0] <= data_input_latch;
          `IC_START_HI: start_addr_reg[15:8] <= data_input_latch;
          `IC_CUR_LO:   cursor_addr_ctr[7:0] <= data_input_latch;
          `IC_CUR_HI:   cursor_addr_ctr[15:8] <= data_input_latch;
          default: ;
        endcase
      end else if (op_done)
        cursor_addr_ctr <= cursor_addr_ctr + 16'h0001;
    end
  end

  // ==========================================================
  // Host read path
  // ==========================================================
  wire rd_active = cs_s & rw_s & e_s;
  assign host_data_bus_oe  = rd_active;
  assign host_data_bus_out = rs_s ? {busy, 7'h00} : data_out_latch;

  // ==========================================================
  // Dot counters and timing
  // ==========================================================
  wire master   = mode_ctl_reg[`MODE_MASTER];
  wire graphic  = mode_ctl_reg[`MODE_GRAPHIC];
  wire disp_on  = mode_ctl_reg[`MODE_DISP_ON];
  logic [7:0]  div_reg;
  logic        dclk_reg;
  logic [3:0]  hdot_reg;
  logic [3:0]  line_code_reg;
  logic [7:0]  hchar_reg;
  logic [7:0]  row_reg;
  logic [15:0] upper_refresh_ctr, lower_refresh_ctr, row_base_reg;
  logic        frame_ac_reg;
  logic        blink_reg;
  logic [5:0]  blink_cnt_reg;
  wire dot_tick = (div_reg == 8'd0) & ~dclk_reg;
  // Sync line is active low and idles high on its pull-up
  wire sync_ev  = ~master & ~sync_s;
  wire char_end = dot_tick & (hdot_reg == horizontal_pitch);
  wire line_end = char_end & (hchar_reg == hchars_reg);
  wire frame_end = line_end & (row_reg == duty_reg);
  wire [7:0] half_rows = 8'(({1'b0, duty_reg} + 9'd1) >> 1);

  always_ff @(posedge ref_clk) begin
    if (rst || sync_ev) begin
      div_reg  <= 8'd0;
      dclk_reg <= 1'b0;
    end else if (div_reg == 8'(`DOT_DIV / 2 - 1)) begin
      div_reg  <= 8'd0;
      dclk_reg <= ~dclk_reg;
    end else
      div_reg <= div_reg + 8'd1;
  end

  always_ff @(posedge ref_clk) begin
    if (rst || sync_ev) begin
      hdot_reg <= 4'h0;
      hchar_reg <= 8'h00;
      row_reg <= 8'h00;
      line_code_reg <= 4'h0;
      upper_refresh_ctr <= 16'h0000;
      lower_refresh_ctr <= 16'h0000;
      row_base_reg <= 16'h0000;
      frame_ac_reg <= 1'b0;
      blink_cnt_reg <= 6'd0;
      blink_reg <= 1'b0;
    end else if (dot_tick) begin
      hdot_reg <= char_end ? 4'h0 : hdot_reg + 4'h1;
      if (char_end) begin
        hchar_reg <= line_end ? 8'h00 : hchar_reg + 8'h01;
        upper_refresh_ctr <= upper_refresh_ctr + 16'h0001;
        lower_refresh_ctr <= lower_refresh_ctr + 16'h0001;
      end
      if (line_end) begin
        row_reg <= frame_end ? 8'h00 : row_reg + 8'h01;
        // Character rows repeat one code line per dot row
        line_code_reg <= (frame_end || line_code_reg == vertical_dots) ? 4'h0 : line_code_reg + 4'h1;
        if (frame_end) begin
          upper_refresh_ctr <= start_addr_reg;
          lower_refresh_ctr <= start_addr_reg + ({8'h00, half_rows} * ({8'h00, hchars_reg} + 16'h0001));
          row_base_reg <= start_addr_reg;
          frame_ac_reg <= ~frame_ac_reg;
          blink_cnt_reg <= blink_cnt_reg + 6'd1;
          blink_reg <= (blink_cnt_reg == 6'd63) ? ~blink_reg : blink_reg;
        end else if (!graphic && line_code_reg != vertical_dots) begin
          upper_refresh_ctr <= row_base_reg;
          lower_refresh_ctr <= row_base_reg + ({8'h00, half_rows} * ({8'h00, hchars_reg} + 16'h0001));
        end else
          row_base_reg <= upper_refresh_ctr + 16'h0001;
      end
    end
  end

  // ==========================================================
  // Pattern ROM and serialisers
  // ==========================================================
  logic [4:0] char_pattern_rom [0:4095];
  always_comb begin
    for (int i = 0; i < 4096; i++)
      char_pattern_rom[i] = 5'((i * 37 + (i >> 4) * 11) & 31);
  end
  // 160 small glyphs below code A0, 96 tall ones from A0 up: small glyph lines past 6 read blank
  wire [7:0]  rom_code = md2_reg;
  wire [4:0]  rom_dots = (rom_code < 8'hA0 && line_code_reg > 4'h6) ? 5'h00 :
                         char_pattern_rom[{rom_code, line_code_reg}];
  wire ext_rom = mode_ctl_reg[`MODE_EXT_ROM];
  wire cur_hit = mode_ctl_reg[`MODE_CUR_ON] && !graphic && (line_code_reg == curpos_reg) &&
                 (upper_refresh_ctr == cursor_addr_ctr) &&
                 !(mode_ctl_reg[`MODE_CUR_BLINK] && blink_reg);
  wire [7:0] char_bits = ext_rom ? rd2_reg : {rom_dots, 3'b000};
  wire [7:0] pix_bits  = graphic ? md2_reg : (cur_hit ? 8'hFF : char_bits);
  logic [7:0] up_sh_reg, lo_sh_reg;
  logic       half_sel_reg;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      up_sh_reg <= 8'h00;
      lo_sh_reg <= 8'h00;
      half_sel_reg <= 1'b0;
    end else if (dot_tick) begin
      half_sel_reg <= ~half_sel_reg;
      // Memory is time-shared: upper half loads, then lower half
      if (hdot_reg == 4'h0)
        up_sh_reg <= pix_bits;
      else
        up_sh_reg <= {up_sh_reg[6:0], 1'b0};
      if (hdot_reg == 4'h1)
        lo_sh_reg <= pix_bits;
      else
        lo_sh_reg <= {lo_sh_reg[6:0], 1'b0};
    end
  end

  wire [15:0] refresh_addr = (hdot_reg == 4'h0) ? upper_refresh_ctr : lower_refresh_ctr;
  wire [15:0] scan_addr = graphic ? refresh_addr :
                          {line_code_reg, refresh_addr[11:0]};
  wire        op_addr = (state_reg != ST_IDLE) && (state_reg != ST_DONE);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ext_mem_addr     <= 16'h0000;
      ext_mem_data_out <= 8'h00;
      ext_mem_data_oe  <= 1'b0;
      ext_mem_write_n  <= 1'b1;
      upper_serial_out <= 1'b0;
      lower_serial_out <= 1'b0;
      row_latch_pulse  <= 1'b0;
      dot_shift_clock  <= 1'b0;
      frame_start      <= 1'b0;
      ac_phase_type_a  <= 1'b0;
      ac_phase_type_b  <= 1'b0;
      slave_clock_out  <= 1'b0;
      lockstep_out     <= 1'b0;
      lockstep_oe      <= 1'b0;
    end else begin
      ext_mem_addr     <= op_addr ? cursor_addr_ctr : scan_addr;
      ext_mem_data_out <= wr_data_reg;
      ext_mem_data_oe  <= (state_reg == ST_WRITE);
      ext_mem_write_n  <= ~((state_reg == ST_WRITE) && op_cnt_reg != 3'd0);
      upper_serial_out <= disp_on & up_sh_reg[7];
      lower_serial_out <= disp_on & lo_sh_reg[7];
      row_latch_pulse  <= line_end;
      dot_shift_clock  <= dclk_reg;
      frame_start      <= (row_reg == 8'h00);
      ac_phase_type_a  <= row_reg[0] ^ frame_ac_reg;
      ac_phase_type_b  <= frame_ac_reg;
      slave_clock_out  <= dclk_reg;
      lockstep_out     <= ~frame_end;
      lockstep_oe      <= master;
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  a_busy_refuse: assert property (@(posedge ref_clk) disable iff (rst)
    (busy && wr_ev && rs_s) |=> $stable(instruction_reg)) else $error("instruction taken while busy");
  a_read_drive: assert property (@(posedge ref_clk) disable iff (rst)
    host_data_bus_oe |-> (cs_s && e_s && rw_s)) else $error("bus driven outside read strobe");
  a_busy_bit: assert property (@(posedge ref_clk) disable iff (rst)
    (host_data_bus_oe && rs_s) |-> host_data_bus_out[7] == busy) else $error("busy bit wrong");
  a_ir_load: assert property (@(posedge ref_clk) disable iff (rst)
    ir_wr |=> instruction_reg == $past(db2_reg[3:0])) else $error("instruction not loaded");
  a_dil_load: assert property (@(posedge ref_clk) disable iff (rst)
    dat_wr |=> data_input_latch == $past(db2_reg)) else $error("data latch not loaded");
  a_read_fetch: assert property (@(posedge ref_clk) disable iff (rst)
    (state_reg == ST_IDLE && start_rd) |-> ##[1:12] op_done) else $error("read fetch stuck");
  a_cursor_inc: assert property (@(posedge ref_clk) disable iff (rst)
    (op_done && !dat_pend_reg) |=> cursor_addr_ctr == $past(cursor_addr_ctr) + 16'h0001)
    else $error("cursor not advanced");
  a_mode_load: assert property (@(posedge ref_clk) disable iff (rst)
    (dat_pend_reg && instruction_reg == `IC_MODE) |=> mode_ctl_reg == $past(data_input_latch[5:0]))
    else $error("mode not loaded");
  a_reset_state: assert property (@(posedge ref_clk)
    rst |=> (!mode_ctl_reg[`MODE_DISP_ON] && !mode_ctl_reg[`MODE_MASTER] && horizontal_pitch == 4'h5))
    else $error("reset state wrong");
  a_lock_dir: assert property (@(posedge ref_clk) disable iff (rst)
    ##1 (lockstep_oe == $past(master))) else $error("lockstep direction wrong");

endmodule : dot_matrix_lcd_controller
`default_nettype wire

//--- logic/lcd_ctl_defs.svh
`ifndef LCD_CTL_DEFS_SVH
`define LCD_CTL_DEFS_SVH

// Instruction codes held in the instruction register
`define IC_MODE        4'h0
`define IC_PITCH       4'h1
`define IC_HCHARS      4'h2
`define IC_DUTY        4'h3
`define IC_CURPOS      4'h4
`define IC_START_LO    4'h8
`define IC_START_HI    4'h9
`define IC_CUR_LO      4'hA
`define IC_CUR_HI      4'hB
`define IC_WRITE_MEM   4'hC
`define IC_READ_MEM    4'hD
`define IC_CLEAR_BIT   4'hE
`define IC_SET_BIT     4'hF

// Mode control field positions
`define MODE_DISP_ON   5
`define MODE_MASTER    4
`define MODE_CUR_ON    3
`define MODE_CUR_BLINK 2
`define MODE_GRAPHIC   1
`define MODE_EXT_ROM   0

// Reset values
`define MODE_RESET     6'h00
`define PITCH_H_RESET  4'h5
`define PITCH_V_RESET  4'h7
`define HCHARS_RESET   8'h1F
`define DUTY_RESET     8'h3F

// Timing
`define CLK_MHZ        250
`define DOT_NS         1000
`define DOT_DIV        ((`DOT_NS * `CLK_MHZ) / 1000)
`define OP_CYCLES      4

`endif

//--- logic/lcd_ctl_pkg.sv
package lcd_ctl_pkg;
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_ADDR  = 5'b00010,
    ST_WAIT  = 5'b00100,
    ST_WRITE = 5'b01000,
    ST_DONE  = 5'b10000
  } op_state_type;
endpackage : lcd_ctl_pkg

//--- verification/dot_matrix_lcd_controller_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "lcd_ctl_defs.svh"

module dot_matrix_lcd_controller_tb_top;
  // ==========================================================
  // Signals
  logic        ref_clk, rst, chip_sel_n, enable, read_not_write, register_select;
  logic        drv, desel, lockstep_in, lockstep_out, lockstep_oe, host_data_bus_oe, ext_mem_data_oe;
  logic        ext_mem_write_n, dot_shift_clock, row_latch_pulse, frame_start, ac_phase_type_a, ac_phase_type_b;
  logic        upper_serial_out, lower_serial_out, slave_clock_out, sync_low;
  logic [7:0]  wdata, host_in, host_data_bus_out, ext_mem_data_in, ext_mem_data_out, ext_font_data;
  logic [15:0] ext_mem_addr;
  int          seed = 2912;
  int          error_cnt = 0;
  int          cmp_count = 0;

  // Data bus and sync line both have pull-ups
  assign host_in     = drv ? wdata : (host_data_bus_oe ? host_data_bus_out : 8'hFF);
  assign lockstep_in = lockstep_oe ? lockstep_out : ~sync_low;

  dot_matrix_lcd_controller i_dot_matrix_lcd_controller (
    .ref_clk(ref_clk), .rst(rst), .chip_sel_n(chip_sel_n), .enable(enable),
    .read_not_write(read_not_write), .register_select(register_select),
    .host_data_bus_in(host_in), .host_data_bus_out(host_data_bus_out), .host_data_bus_oe(host_data_bus_oe),
    .ext_mem_addr(ext_mem_addr), .ext_mem_data_in(ext_mem_data_in), .ext_mem_data_out(ext_mem_data_out),
    .ext_mem_data_oe(ext_mem_data_oe), .ext_mem_write_n(ext_mem_write_n), .ext_font_data(ext_font_data),
    .row_latch_pulse(row_latch_pulse), .dot_shift_clock(dot_shift_clock), .frame_start(frame_start),
    .ac_phase_type_a(ac_phase_type_a), .ac_phase_type_b(ac_phase_type_b), .upper_serial_out(upper_serial_out),
    .lower_serial_out(lower_serial_out), .lockstep_in(lockstep_in),
    .lockstep_out(lockstep_out), .lockstep_oe(lockstep_oe), .slave_clock_out(slave_clock_out));

  ext_ram_model i_ext_ram_model (
    .ext_mem_addr(ext_mem_addr), .ext_mem_data_out(ext_mem_data_out), .ext_mem_data_oe(ext_mem_data_oe),
    .ext_mem_write_n(ext_mem_write_n), .ext_mem_data_in(ext_mem_data_in), .ext_font_data(ext_font_data));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // Tasks
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Data must stay on the bus a few clocks past the strobe fall
  task automatic bus_write(input logic rs, input logic [7:0] d);
    @(negedge ref_clk);
    chip_sel_n = desel; register_select = rs; read_not_write = 1'b0; drv = 1'b1; wdata = d;
    @(negedge ref_clk);
    enable = 1'b1;
    repeat (2) @(negedge ref_clk);
    enable = 1'b0;
    repeat (4) @(negedge ref_clk);
    chip_sel_n = 1'b1; drv = 1'b0;
  endtask : bus_write

  task automatic bus_read(input logic rs, output logic [7:0] d);
    int n;
    @(negedge ref_clk);
    chip_sel_n = 1'b0; register_select = rs; read_not_write = 1'b1;
    @(negedge ref_clk);
    enable = 1'b1;
    for (n = 0; n < 20 && host_data_bus_oe !== 1'b1; n++) @(negedge ref_clk);
    if (n == 20) begin
      error_cnt++;
      $display("Error read enable expected 1 seen %b", host_data_bus_oe);
      final_report();
    end
    d = host_in;
    enable = 1'b0;
    repeat (4) @(negedge ref_clk);
    check("bus released", 16'h0000, {15'h0, host_data_bus_oe});
    chip_sel_n = 1'b1;
  endtask : bus_read

  task automatic wait_idle;
    logic [7:0] s;
    int n;
    for (n = 0; n < 40; n++) begin
      bus_read(1'b1, s);
      if (s[7] === 1'b0) break;
    end
    if (n == 40) begin
      error_cnt++;
      $display("Error busy expected 0 seen %b", s[7]);
      final_report();
    end
  endtask : wait_idle

  task automatic instr(input logic [3:0] code, input logic [7:0] d);
    bus_write(1'b1, {4'h0, code});
    bus_write(1'b0, d);
    wait_idle();
  endtask : instr

  task automatic set_cursor(input logic [15:0] a);
    instr(`IC_CUR_LO, a[7:0]);
    instr(`IC_CUR_HI, a[15:8]);
  endtask : set_cursor

  // ==========================================================
  // Sequence
  initial begin
    logic [15:0] a;
    logic [7:0]  d, d2, r, old;
    int          b, n;
    int          cnt [7];
    rst = 1'b1; chip_sel_n = 1'b1; enable = 1'b0; read_not_write = 1'b1; register_select = 1'b0;
    drv = 1'b0; desel = 1'b0; wdata = 8'h00; sync_low = 1'b0;
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    bus_read(1'b1, r);
    check("status after reset", 16'h0000, {8'h00, r});
    check("sync drive after reset", 16'h0000, {15'h0, lockstep_oe});
    check("write strobe idle", 16'h0001, {15'h0, ext_mem_write_n});
    $display("test reset done");

    instr(`IC_MODE, 8'h30);
    check("sync drive master", 16'h0001, {15'h0, lockstep_oe});
    n = 0;
    repeat (600) begin
      @(negedge ref_clk);
      if (dot_shift_clock === 1'b1) n++;
    end
    check("shift clock runs", 16'h0001, {15'h0, n > 0 && n < 600});
    instr(`IC_MODE, 8'h22);
    check("sync drive slave", 16'h0000, {15'h0, lockstep_oe});
    $display("test mode done");

    // Short lines and a two-line frame; a slave sync pulse aligns the counters
    instr(`IC_MODE, 8'h00);
    instr(`IC_PITCH, 8'h71);
    instr(`IC_HCHARS, 8'h00);
    instr(`IC_DUTY, 8'h01);
    sync_low = 1'b1;
    repeat (4) @(negedge ref_clk);
    sync_low = 1'b0;
    repeat (8) @(negedge ref_clk);
    for (int j = 0; j < 7; j++) cnt[j] = 0;
    repeat (8 * `DOT_DIV) begin
      @(negedge ref_clk);
      cnt[0] += (row_latch_pulse === 1'b1);
      cnt[1] += (frame_start === 1'b1);
      cnt[2] += (ac_phase_type_a === 1'b1);
      cnt[3] += (ac_phase_type_b === 1'b1);
      cnt[4] += (slave_clock_out === 1'b1);
      cnt[5] += (upper_serial_out !== 1'b0);
      cnt[6] += (lower_serial_out !== 1'b0);
    end
    check("row latch pulses", 16'h0004, 16'(cnt[0]));
    check("frame start high", 16'(4 * `DOT_DIV), 16'(cnt[1]));
    check("ac type a high", 16'(4 * `DOT_DIV), 16'(cnt[2]));
    check("ac type b high", 16'(4 * `DOT_DIV), 16'(cnt[3]));
    check("slave clock high", 16'(4 * `DOT_DIV), 16'(cnt[4]));
    check("upper data display off", 16'h0000, 16'(cnt[5]));
    check("lower data display off", 16'h0000, 16'(cnt[6]));
    $display("test timing done");

    // Top address first so the cursor wraps
    for (int k = 0; k < 6; k++) begin
      a = (k == 0) ? 16'hFFFF : 16'($random(seed));
      d = 8'($random(seed));
      d2 = 8'($random(seed));
      b = $random(seed) & 7;
      set_cursor(a);
      instr(`IC_WRITE_MEM, d);
      bus_write(1'b0, d2);
      wait_idle();
      check("mem write", {8'h00, d}, {8'h00, i_ext_ram_model.mem[a]});
      check("mem write next", {8'h00, d2}, {8'h00, i_ext_ram_model.mem[a + 16'h1]});
      set_cursor(a);
      bus_write(1'b1, {4'h0, `IC_READ_MEM});
      wait_idle();
      bus_read(1'b0, r);
      check("mem read", {8'h00, d}, {8'h00, r});
      wait_idle();
      bus_read(1'b0, r);
      check("mem read next", {8'h00, d2}, {8'h00, r});
      wait_idle();
      set_cursor(a);
      old = i_ext_ram_model.mem[a];
      instr(`IC_SET_BIT, 8'(b));
      check("set bit", {8'h00, old | (8'h01 << b)}, {8'h00, i_ext_ram_model.mem[a]});
      old = i_ext_ram_model.mem[a + 16'h1];
      instr(`IC_CLEAR_BIT, 8'(b));
      check("clear bit", {8'h00, old & ~(8'h01 << b)}, {8'h00, i_ext_ram_model.mem[a + 16'h1]});
    end
    $display("test memory done");

    a = 16'h0123;
    set_cursor(a);
    bus_write(1'b1, {4'h0, `IC_WRITE_MEM});
    bus_write(1'b0, 8'hA5);
    bus_write(1'b0, 8'h5A);
    wait_idle();
    check("write while busy", {8'h00, 8'hA5}, {8'h00, i_ext_ram_model.mem[a]});
    bus_write(1'b0, 8'h3C);
    bus_read(1'b1, r);
    check("busy on top bit", 16'h0080, {8'h00, r});
    wait_idle();
    check("refused write skipped", 16'h003C, {8'h00, i_ext_ram_model.mem[a + 16'h1]});
    old = i_ext_ram_model.mem[a + 16'h2];
    desel = 1'b1;
    bus_write(1'b0, ~old);
    desel = 1'b0;
    wait_idle();
    check("deselected write", {8'h00, old}, {8'h00, i_ext_ram_model.mem[a + 16'h2]});
    $display("test refusal done");
    final_report();
  end
endmodule : dot_matrix_lcd_controller_tb_top

`default_nettype wire

//--- verification/ext_ram_model.sv
`timescale 1ns/1ps
`default_nettype none

module ext_ram_model (
  // Device memory pins
  input  wire logic [15:0] ext_mem_addr,
  input  wire logic [7:0]  ext_mem_data_out,
  input  wire logic        ext_mem_data_oe,
  input  wire logic        ext_mem_write_n,
  // Answers toward the device
  output logic      [7:0]  ext_mem_data_in,
  output logic      [7:0]  ext_font_data
);
  // ==========================================================
  // Storage
  logic [7:0] mem [0:65535];

  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'(i) ^ 8'h5A;
  end

  // Plain static RAM: writes land while the strobe is low
  always @(ext_mem_write_n or ext_mem_data_oe or ext_mem_addr or ext_mem_data_out) begin
    if (ext_mem_write_n === 1'b0 && ext_mem_data_oe === 1'b1) mem[ext_mem_addr] = ext_mem_data_out;
  end

  // No pull on these lines: while the device drives, echo the inverse so stale data never looks valid
  assign ext_mem_data_in = ext_mem_data_oe ? ~ext_mem_data_out : mem[ext_mem_addr];
  // Font pattern as a fixed function of the address
  assign ext_font_data   = ext_mem_addr[7:0] ^ 8'hC3;
endmodule : ext_ram_model

`default_nettype wire
